// ===== rtl/sqrf_defines.svh
// Constants for the squib driver response formatter
// Summary of operation
// - Diagnostic response mode bits 15:14 are 1 then 0.
// - Diagnostic bit 13 is battery-short comparator: 1 above threshold.
// - Diagnostic and status bit 12 mirror deploy enable pin level.
// - Diagnostic bit 11 is live self-test in-progress flag, unlatched.
// - Diagnostic bit 10 selects transistor test: 0 low side, 1 high side.
// - Bit 9 diagnostic current on; bit 8 current select, 1 source current.
// - Diagnostic bit 7 ground-short comparator: 1 when low pin below threshold.
// - Diagnostic bits 6:4 carry measured channel number.
// - Diagnostic bit 3 is squib current comparator: 1 above threshold.
// - Diagnostic bits 2:0 carry diagnostic current channel number.
// - Status response mode bits 11, bit 13 zero, bits 11,10,7:4 zero.
// - Status bits 9,8 arming pair high and low; deploy stretch excluded.
// - Arming flags change only after the deglitch timer expires.
// - Status bits 3:0 per-channel deploy info chosen by monitor select.
// - Parity is checked; faulty previous command gives bits 15:13 set.
// - Parity or deploy message error clears fault bits 12 and 11.
// - Wrong clock or bit count sets fault bit 12.
// - Nonexistent diagnostic channel sets fault bit 11.
// - Diagnostic channel addresses 4 to 7 are invalid.
// - Fault words are E000h, F000h and E800h.
`ifndef SQRF_DEFINES_SVH
`define SQRF_DEFINES_SVH
`define SQRF_WORD_BITS    16
`define SQRF_MODE_DIAG    2'h2
`define SQRF_MODE_STATUS  2'h3
`define SQRF_FAULT_PARITY 16'hE000
`define SQRF_FAULT_CLOCKS 16'hF000
`define SQRF_FAULT_CHAN   16'hE800
`define SQRF_CHAN_LIMIT   3'h4
`define SQRF_CNT_DONE     5'h10
`define SQRF_CNT_MAX      5'h1F
`define SQRF_CMD_DIAG     2'h1
`define SQRF_CMD_STATUS   2'h2
`define SQRF_BITCNT_W     5
`endif

// ===== rtl/sqrf_pkg.sv
// Types for the squib driver response formatter
package sqrf_pkg;
  typedef enum logic [1:0]
  {
    SQRF_RESP_NONE   = 2'b00,
    SQRF_RESP_DIAG   = 2'b01,
    SQRF_RESP_STATUS = 2'b10,
    SQRF_RESP_FAULT  = 2'b11
  } sqrf_resp_t;
endpackage

// ===== rtl/sqrf_word_if.sv
// Word and event carrier between system and link domains
`timescale 1ns/1ps
interface sqrf_word_if;
  logic [15:0] word;
  logic [15:0] rx_word;
  logic        rx_bad_count;
  logic        rx_tgl;
  modport sys  (output word, input rx_word, input rx_bad_count, input rx_tgl);
  modport link (input word, output rx_word, output rx_bad_count, output rx_tgl);
endinterface

// ===== rtl/sqrf_shifter.sv
// Link-domain shift register on the host serial clock
`timescale 1ns/1ps
`include "sqrf_defines.svh"
module sqrf_shifter
  import sqrf_pkg::*;
(
  input  wire logic sclk,
  input  wire logic rst_n,
  input  wire logic cs_n,
  input  wire logic mosi,
  output logic      miso,
  output logic      miso_oe,
  sqrf_word_if.link wif
);
  logic [15:0]                tx_reg;
  logic [15:0]                rx_reg;
  logic [`SQRF_BITCNT_W-1:0]  cnt_reg;
  logic                       active_reg;
  logic                       tgl_reg;
  logic [15:0]                out_reg;
  logic                       bad_reg;

  // Load on first falling edge after select, shift on later falling edges, capture on rising edge
  always_ff @(negedge sclk or posedge cs_n or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_reg <= 1'b0;
      tx_reg     <= 16'h0000;
    end
    else if (cs_n)
    begin
      active_reg <= 1'b0;
      tx_reg     <= 16'h0000;
    end
    else if (!active_reg)
    begin
      active_reg <= 1'b1;
      tx_reg     <= {wif.word[14:0], 1'b0};
    end
    else
      tx_reg <= {tx_reg[14:0], 1'b0};
  end

  // Clock counter, saturating so long frames stay flagged
  always_ff @(posedge sclk or posedge cs_n or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else if (cs_n)
      cnt_reg <= '0;
    else if (cnt_reg != `SQRF_CNT_MAX)
      cnt_reg <= cnt_reg + 5'h01;
  end

  always_ff @(posedge sclk)
    rx_reg <= {rx_reg[14:0], mosi};

  // Frame end is taken on select release; toggle needs a known start
  always_ff @(posedge cs_n or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_reg <= 16'h0000;
      bad_reg <= 1'b0;
      tgl_reg <= 1'b0;
    end
    else
    begin
      out_reg <= rx_reg;
      bad_reg <= (cnt_reg != `SQRF_CNT_DONE);
      tgl_reg <= ~tgl_reg;
    end
  end

  assign miso         = active_reg ? tx_reg[15] : wif.word[15];
  assign miso_oe      = ~cs_n;
  assign wif.rx_word  = out_reg;
  assign wif.rx_bad_count = bad_reg;
  assign wif.rx_tgl   = tgl_reg;
endmodule

// ===== rtl/sqrf_formatter.sv
// Response word formatter for the deployment driver serial port
`timescale 1ns/1ps
`include "sqrf_defines.svh"
module sqrf_formatter
  import sqrf_pkg::*;
#(
  parameter int CHAN_COUNT = `SQRF_CHAN_LIMIT
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso,
  output logic            miso_oe,
  input  wire logic       deploy_enable_pin,
  input  wire logic       batt_short_cmp,
  input  wire logic       gnd_short_cmp_above,
  input  wire logic       squib_current_cmp,
  input  wire logic       mos_test_busy,
  input  wire logic       mos_test_high_side,
  input  wire logic       diag_current_on,
  input  wire logic       diag_current_src_sel,
  input  wire logic [2:0] measure_channel,
  input  wire logic [2:0] diag_current_channel,
  input  wire logic       arming_pair_high,
  input  wire logic       arming_pair_low,
  input  wire logic       arm_deglitch_done,
  input  wire logic       monitor_select,
  input  wire logic [3:0] deploy_success_flags,
  input  wire logic [3:0] deploy_active_flags,
  input  wire logic       cmd_valid,
  input  wire logic [1:0] cmd_kind,
  input  wire logic       cmd_parity_ok,
  input  wire logic       cmd_deploy_msg_err,
  input  wire logic [2:0] cmd_channel,
  output logic [15:0]     last_cmd_word,
  output logic            last_cmd_strobe
);
  sqrf_word_if wif ();

  // Channel count must fit the 3-bit channel field
  if (CHAN_COUNT < 1 || CHAN_COUNT > 8)
  begin : g_chan_check
    $error("channel count out of range");
  end

  localparam logic [3:0] CHAN_LIMIT = 4'(CHAN_COUNT);

  sqrf_shifter u_shift
  (
    .sclk    (sclk),
    .rst_n   (rst_n),
    .cs_n    (cs_n),
    .mosi    (mosi),
    .miso    (miso),
    .miso_oe (miso_oe),
    .wif     (wif)
  );

  // Two-stage synchronisers for the deploy pin, the three comparators and the link-domain toggle
  logic [1:0] dep_s;
  logic [1:0] bsc_s;
  logic [1:0] gsc_s;
  logic [1:0] sqc_s;
  logic [1:0] tgl_s;
  logic       tgl_d;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dep_s <= 2'h0;
      bsc_s <= 2'h0;
      gsc_s <= 2'h0;
      sqc_s <= 2'h0;
      tgl_s <= 2'h0;
      tgl_d <= 1'b0;
    end
    else
    begin
      dep_s <= {dep_s[0], deploy_enable_pin};
      bsc_s <= {bsc_s[0], batt_short_cmp};
      gsc_s <= {gsc_s[0], gnd_short_cmp_above};
      sqc_s <= {sqc_s[0], squib_current_cmp};
      tgl_s <= {tgl_s[0], wif.rx_tgl};
      tgl_d <= tgl_s[1];
    end
  end

  // Frame received event passes the captured word to the command decoder
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      last_cmd_word   <= 16'h0000;
      last_cmd_strobe <= 1'b0;
    end
    else
    begin
      last_cmd_strobe <= tgl_s[1] ^ tgl_d;
      if (tgl_s[1] ^ tgl_d)
        last_cmd_word <= wif.rx_word;
    end
  end

  // Arming flags update only after the deglitch timer expires
  logic arm_hi_reg;
  logic arm_lo_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      arm_hi_reg <= 1'b0;
      arm_lo_reg <= 1'b0;
    end
    else if (arm_deglitch_done)
    begin
      arm_hi_reg <= arming_pair_high;
      arm_lo_reg <= arming_pair_low;
    end
  end

  // Response type and fault chosen by previous command
  sqrf_resp_t  resp_reg;
  logic [15:0] fault_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      resp_reg  <= SQRF_RESP_NONE;
      fault_reg <= `SQRF_FAULT_PARITY;
    end
    else if (last_cmd_strobe)
    begin
      if (wif.rx_bad_count)
      begin
        resp_reg  <= SQRF_RESP_FAULT;
        fault_reg <= `SQRF_FAULT_CLOCKS;
      end
      else if (cmd_valid && (!cmd_parity_ok || cmd_deploy_msg_err))
      begin
        resp_reg  <= SQRF_RESP_FAULT;
        fault_reg <= `SQRF_FAULT_PARITY;
      end
      else if (cmd_valid && cmd_kind == `SQRF_CMD_DIAG &&
               {1'b0, cmd_channel} >= CHAN_LIMIT)
      begin
        resp_reg  <= SQRF_RESP_FAULT;
        fault_reg <= `SQRF_FAULT_CHAN;
      end
      else if (cmd_valid && cmd_kind == `SQRF_CMD_DIAG)
        resp_reg <= SQRF_RESP_DIAG;
      else if (cmd_valid && cmd_kind == `SQRF_CMD_STATUS)
        resp_reg <= SQRF_RESP_STATUS;
      else
        resp_reg <= SQRF_RESP_NONE;
    end
  end

  // Word assembly, held in a register and read by the link at select
  logic [15:0] word_reg;
  logic [15:0] word_next;
  logic [3:0]  dep_info;

  always_comb
  begin
    dep_info  = monitor_select ? deploy_active_flags : deploy_success_flags;
    word_next = 16'h0000;
    case (resp_reg)
      SQRF_RESP_DIAG:
      begin
        word_next[15:14] = `SQRF_MODE_DIAG;
        word_next[13]    = bsc_s[1];
        word_next[12]    = dep_s[1];
        word_next[11]    = mos_test_busy;
        word_next[10]    = mos_test_high_side;
        word_next[9]     = diag_current_on;
        word_next[8]     = diag_current_src_sel;
        word_next[7]     = ~gsc_s[1];
        word_next[6:4]   = measure_channel;
        word_next[3]     = sqc_s[1];
        word_next[2:0]   = diag_current_channel;
      end
      SQRF_RESP_STATUS:
      begin
        word_next[15:14] = `SQRF_MODE_STATUS;
        word_next[12]    = dep_s[1];
        word_next[9]     = arm_hi_reg;
        word_next[8]     = arm_lo_reg;
        word_next[3:0]   = dep_info;
      end
      SQRF_RESP_FAULT:
        word_next = fault_reg;
      default:
        word_next = 16'h0000;
    endcase
  end

  // Word frozen while the two-stage synchronised select is low so the link sees a stable value
  logic [1:0] cs_s;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cs_s     <= 2'h3;
      word_reg <= 16'h0000;
    end
    else
    begin
      cs_s <= {cs_s[0], cs_n};
      if (cs_s[1])
        word_reg <= word_next;
    end
  end

  assign wif.word     = word_reg;
endmodule

// ===== sim/sqrf_formatter_chk.sv
// Port checks on the response formatter
`timescale 1ns/1ps
module sqrf_formatter_chk
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        miso_oe,
  input wire logic        last_cmd_strobe,
  input wire logic [15:0] last_cmd_word
);
  sequence s_cs_rise;
    !cs_n ##1 cs_n;
  endsequence
  property p_strobe_late;
    @(posedge clk) disable iff (!rst_n) s_cs_rise |-> ##[1:8] last_cmd_strobe;
  endproperty
  a_strobe_late: assert property (p_strobe_late) else $error("no strobe");
  property p_strobe_early;
    @(posedge clk) disable iff (!rst_n) s_cs_rise |-> !last_cmd_strobe ##1 !last_cmd_strobe;
  endproperty
  a_strobe_early: assert property (p_strobe_early) else $error("early strobe");
  property p_strobe_once;
    @(posedge clk) disable iff (!rst_n) last_cmd_strobe |=> !last_cmd_strobe [*8];
  endproperty
  a_strobe_once: assert property (p_strobe_once) else $error("strobe repeats");
  property p_strobe_idle;
    @(posedge clk) disable iff (!rst_n) last_cmd_strobe |-> cs_n && $past(cs_n, 2);
  endproperty
  a_strobe_idle: assert property (p_strobe_idle) else $error("strobe in frame");
  property p_oe_off;
    @(posedge clk) disable iff (!rst_n) cs_n [*3] |-> !miso_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("driving while idle");
  property p_oe_on;
    @(posedge clk) disable iff (!rst_n) !cs_n [*3] |-> miso_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("not driving in frame");
  property p_oe_sclk;
    @(posedge sclk) disable iff (!rst_n) !cs_n |-> miso_oe;
  endproperty
  a_oe_sclk: assert property (p_oe_sclk) else $error("not driving at edge");
  property p_word_hold;
    @(posedge clk) disable iff (!rst_n) $changed(last_cmd_word) |-> cs_n;
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word moved in frame");
endmodule
bind sqrf_formatter sqrf_formatter_chk u_chk (.clk(clk), .rst_n(rst_n), .sclk(sclk),
  .cs_n(cs_n), .miso_oe(miso_oe), .last_cmd_strobe(last_cmd_strobe),
  .last_cmd_word(last_cmd_word));

// ===== sim/sqrf_host.sv
// Host serial master model
`timescale 1ns/1ps
module sqrf_host
(
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Frame of n clocks, MSB first, sclk still between frames
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    logic [31:0] sh;
    sh = {tx, tx};
    rx = 16'h0000;
    cs_n = 1'b0;
    mosi = sh[31];
    #62.5;
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'b1;
      rx = {rx[14:0], miso};
      #62.5;
      sclk = 1'b0;
      sh = sh << 1;
      mosi = sh[31];
      #62.5;
    end
    cs_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// ===== sim/tb_squib_driver_miso_response_formatter.sv
// Testbench for the response formatter
`timescale 1ns/1ps
module tb_squib_driver_miso_response_formatter;
  import sqrf_pkg::*;
  typedef struct packed
  {
    logic [4:0]  ncl;
    logic [1:0]  kind;
    logic        pok;
    logic        merr;
    logic        dg;
    logic [2:0]  ch;
    logic [24:0] lv;
    logic [15:0] exp;
  } sqrf_row_t;
  localparam sqrf_row_t ROWS [12] = '{
    '{5'h10, 2'h1, 1'b1, 1'b0, 1'b1, 3'h3, 25'h1B55800, 16'hBADB},
    '{5'h10, 2'h1, 1'b1, 1'b0, 1'b1, 3'h0, 25'h04AA800, 16'h8525},
    '{5'h10, 2'h2, 1'b1, 1'b0, 1'b1, 3'h0, 25'h119C4A5, 16'hD20A},
    '{5'h10, 2'h2, 1'b1, 1'b0, 1'b1, 3'h0, 25'h00003A5, 16'hC105},
    '{5'h10, 2'h2, 1'b1, 1'b0, 1'b0, 3'h0, 25'h00005A5, 16'hC105},
    '{5'h10, 2'h2, 1'b1, 1'b0, 1'b1, 3'h0, 25'h00005A5, 16'hC205},
    '{5'h10, 2'h1, 1'b0, 1'b0, 1'b1, 3'h1, 25'h1B55800, 16'hE000},
    '{5'h10, 2'h2, 1'b1, 1'b1, 1'b1, 3'h0, 25'h1B55800, 16'hE000},
    '{5'h10, 2'h1, 1'b1, 1'b0, 1'b1, 3'h4, 25'h1B55800, 16'hE800},
    '{5'h10, 2'h1, 1'b1, 1'b0, 1'b1, 3'h7, 25'h1B55800, 16'hE800},
    '{5'h0F, 2'h1, 1'b1, 1'b0, 1'b1, 3'h1, 25'h1B55800, 16'hF000},
    '{5'h11, 2'h1, 1'b0, 1'b0, 1'b1, 3'h4, 25'h1B55800, 16'hF000}
  };
  logic        clk;
  logic        rst_n;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic [24:0] lv;
  logic        dg;
  logic [1:0]  kind;
  logic        pok;
  logic        merr;
  logic        vld;
  logic [2:0]  ch;
  logic [15:0] last_cmd_word;
  logic [15:0] rx;
  int          failures;
  int          n_compared;
  sqrf_host h (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  sqrf_formatter uut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(), .deploy_enable_pin(lv[24]), .batt_short_cmp(lv[23]),
    .gnd_short_cmp_above(lv[22]), .squib_current_cmp(lv[21]), .mos_test_busy(lv[20]),
    .mos_test_high_side(lv[19]), .diag_current_on(lv[18]), .diag_current_src_sel(lv[17]),
    .measure_channel(lv[16:14]), .diag_current_channel(lv[13:11]),
    .arming_pair_high(lv[10]), .arming_pair_low(lv[9]), .arm_deglitch_done(dg),
    .monitor_select(lv[8]), .deploy_success_flags(lv[7:4]), .deploy_active_flags(lv[3:0]),
    .cmd_valid(vld), .cmd_kind(kind), .cmd_parity_ok(pok), .cmd_deploy_msg_err(merr),
    .cmd_channel(ch), .last_cmd_word(last_cmd_word), .last_cmd_strobe());
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] r);
    @(posedge clk);
    #1;
    h.xfer(tx, n, r);
    repeat (12) @(posedge clk);
  endtask
  initial
  begin
    #1_000_000;
    failures++;
    give_verdict;
  end
  initial
  begin
    failures = 0;
    n_compared = 0;
    #1 rst_n = 1'b0;
    vld = 1'b1;
    lv = 25'h0000000;
    dg = 1'b1;
    kind = 2'h0;
    pok = 1'b1;
    merr = 1'b0;
    ch = 3'h0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    frame(16'h0000, 16, rx);
    chk(rx, 16'h0000);
    foreach (ROWS[i])
    begin
      @(posedge clk);
      #1 {kind, pok, merr, dg, ch, lv} = {ROWS[i].kind, ROWS[i].pok, ROWS[i].merr,
        ROWS[i].dg, ROWS[i].ch, ROWS[i].lv};
      frame(16'(16'h5A00 + i), int'(ROWS[i].ncl), rx);
      frame(16'(16'hC300 + i), 16, rx);
      chk(rx, ROWS[i].exp);
      chk(last_cmd_word, 16'(16'hC300 + i));
    end
    // Invalid decode and unknown command answer with the empty word
    @(posedge clk);
    #1 {vld, kind, pok, merr} = {1'b0, 2'h1, 1'b0, 1'b0};
    frame(16'h0F0F, 16, rx);
    chk(rx, 16'hE000);
    #1 vld = 1'b1;
    frame(16'hF0F0, 16, rx);
    chk(rx, 16'h0000);
    #1 {kind, pok} = {2'h3, 1'b1};
    frame(16'h3C3C, 16, rx);
    chk(rx, 16'hE000);
    frame(16'hC3C3, 16, rx);
    chk(rx, 16'h0000);
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    frame(16'h1234, 16, rx);
    chk(rx, 16'h0000);
    give_verdict;
  end
endmodule
